/* rtl/ssos_top.sv */
// Safe stop one sequencer: two-channel stop timing, braking monitors, torque-off.
// Assumes speeds arrive on aclk; selection and system error pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none

// How it works
// R1: On selection, ramp down on quick stop; torque-off at delay expiry or low speed.
// R2: Delay timer starts at selection, never aborts; early deselect gives torque-off pulse.
// R3: Mode 0 with encoder supervises braking with the acceleration monitor.
// R4: Mode 2 with encoder supervises braking with the brake-ramp monitor.
// R5: Mode 3 without encoder is acceleration monitor plus delay, as encoder case.
// R6: Mode 1 without encoder uses brake-ramp monitor, no timer, speed threshold only.
// R7: External-stop variant needs function config bit 3 and the ordinary enable.
// R8: External stop: no ramp; expiry gives torque-off and brake control only.
// R9: External stop: no brake-ramp, acceleration or standstill monitoring during delay.
// R10: External stop: torque-off follows timer expiry even if brake-ramp is configured.
// R11: While selected, all three speed setpoint limit elements read zero.
// R12: System error runs stop F, then stop B, then stop A, raising message 1711.
// R13: Status bit 1 shows stop active; bit 0 shows torque-off active.
// R14: Selection and monitoring run in two channels; ramp command from one only.
// R15: Configurator should set delay at least ramp time plus brake times.
// R16: Each clock both channels compare speed; while the stop is active they advance their timers together.
module ssos_top (
	// Clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// Safety selections (asynchronous pins)
	input  wire logic [1:0]              select_pin,
	input  wire logic                    sys_error_pin,
	// Measured speed magnitude per channel
	input  wire logic [15:0]             speed_ch0,
	input  wire logic [15:0]             speed_ch1,
	// Drive outputs
	output logic                         safe_torque_off,
	output logic                         safe_brake_control,
	output logic                         quick_stop_ramp,
	output ssos_pkg::ssos_spd_lim_t      speed_setpoint_limit_out,
	output ssos_pkg::ssos_status_t       integrated_status_word,
	output logic                         irq
);
	import ssos_pkg::*;

	ssos_state_t          state_q, state_d;
	logic [2:0]           ctrl_q;
	logic [1:0]           mode_q;
	logic [7:0]           fcfg_q;
	logic [31:0]          delay_q;
	logic [15:0]          thr_q, tol_q, slope_q, limit_q, msg_q;
	logic [IRQ_N-1:0]     ien_q, istat_q, istat_d, iclr;
	logic [1:0]           sel_s1_q, sel_s2_q;
	logic [2:0]           sys_s_q;
	logic                 force_b_q, toff_q;
	logic                 aw_full_q, w_full_q;
	logic [7:0]           awaddr_q;
	logic [31:0]          wdata_q;
	logic [3:0]           wstrb_q;
	logic                 wr_go;
	logic [15:0]          spd [2];
	logic [31:0]          timer_q [2];
	logic [16:0]          ref_q [2];
	logic [1:0]           sel_ch, done_ch, viol_ch;
	logic                 sel, done, viol, sys_evt, start, in_stop;
	logic                 enc, ext, use_timer, use_ramp, use_acc;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Synchronisers: only the second stage feeds logic, plus the third for the system error edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_s1_q <= 2'h0;
			sel_s2_q <= 2'h0;
			sys_s_q  <= 3'h0;
		end else begin
			sel_s1_q <= select_pin;
			sel_s2_q <= sel_s1_q;
			sys_s_q  <= {sys_s_q[1:0], sys_error_pin};
		end
	end

	// Configuration decode
	always_comb begin
		enc       = ctrl_q[CTRL_ENC];
		ext       = ctrl_q[CTRL_EN] && fcfg_q[FCFG_EXT] && !force_b_q;  // [R7]
		use_ramp  = !ext && ((enc && mode_q == MODE_RAMP_ENC) ||
			(!enc && mode_q == MODE_RAMP_NOENC));                       // [R4] [R6] [R9]
		use_acc   = !ext && !use_ramp;                                 // [R3] [R5] [R9]
		use_timer = ext || !(!enc && mode_q == MODE_RAMP_NOENC);       // [R6] [R10]
		sel_ch    = {2{ctrl_q[CTRL_EN]}} & (sel_s2_q | {2{ctrl_q[CTRL_SEL]}}); // [R14]
		sel       = |sel_ch || force_b_q;
		sys_evt   = sys_s_q[1] && !sys_s_q[2];
		spd[0]    = speed_ch0;
		spd[1]    = speed_ch1;
	end

	// Two independent channels, sampled in the same cycle
	for (genvar i = 0; i < 2; i++) begin : g_ch
		logic [16:0] acc_lim;
		assign acc_lim = ref_q[i] + {1'b0, tol_q};
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				timer_q[i] <= 32'h0;
				ref_q[i]   <= 17'h0;
			end else if (start) begin
				timer_q[i] <= delay_q;                                   // [R2]
				ref_q[i]   <= use_ramp ? {1'b0, spd[i]} + {1'b0, tol_q} : {1'b0, spd[i]};
			end else if (state_q == ST_ACTIVE) begin
				if (timer_q[i] != 32'h0) begin
					timer_q[i] <= timer_q[i] - 32'h1;                    // [R16]
				end
				if (use_ramp) begin
					ref_q[i] <= (ref_q[i] > {1'b0, slope_q} + {1'b0, thr_q}) ?
						ref_q[i] - {1'b0, slope_q} : {1'b0, thr_q};      // [R4]
				end else if ({1'b0, spd[i]} < ref_q[i]) begin
					ref_q[i] <= {1'b0, spd[i]};                          // [R3]
				end
			end
		end
		// Expiry or low speed, whichever first; external stop ignores speed
		assign done_ch[i] = (use_timer && timer_q[i] == 32'h0) ||
			(!ext && spd[i] < thr_q);                                    // [R1] [R10] [R16]
		assign viol_ch[i] = state_q == ST_ACTIVE && !start &&
			((use_acc && {1'b0, spd[i]} > acc_lim) ||
			(use_ramp && {1'b0, spd[i]} > ref_q[i]));                    // [R3] [R4] [R14]
	end

	assign done = |done_ch;
	assign viol = |viol_ch;

	// Stop sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (sys_evt) begin
					state_d = ST_STOP_F;                                 // [R12]
				end else if (sel) begin
					state_d = ST_ACTIVE;                                 // [R1]
				end
			end
			ST_ACTIVE: begin
				if (sys_evt && !force_b_q) begin
					state_d = ST_STOP_F;
				end else if (viol) begin
					state_d = ST_STOP_A;
				end else if (done) begin
					// Deselect does not abort: run to expiry or low speed first
					state_d = force_b_q ? ST_STOP_A : ST_TORQUE_OFF;     // [R2] [R12]
				end
			end
			ST_TORQUE_OFF: begin
				if (sys_evt) begin
					state_d = ST_STOP_F;
				end else if (!sel) begin
					state_d = ST_IDLE;                                   // [R2]
				end
			end
			ST_STOP_F: begin
				state_d = ST_ACTIVE;                                     // [R12]
			end
			ST_STOP_A: begin
				if (!ctrl_q[CTRL_EN]) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_STOP_A;
			end
		endcase
	end

	assign start   = state_d == ST_ACTIVE && state_q != ST_ACTIVE;
	assign in_stop = state_q == ST_ACTIVE || state_q == ST_STOP_F;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q   <= ST_IDLE;
			force_b_q <= 1'b0;
			msg_q     <= 16'h0;
		end else begin
			state_q <= state_d;
			if (state_d == ST_STOP_F) begin
				force_b_q <= 1'b1;
				msg_q     <= MSG_SYS_ERR;                                // [R12]
			end else if (state_d == ST_IDLE) begin
				force_b_q <= 1'b0;
			end
		end
	end

	// Drive outputs, all registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			toff_q                   <= 1'b0;
			safe_brake_control       <= 1'b0;
			quick_stop_ramp          <= 1'b0;
			speed_setpoint_limit_out <= '0;
			integrated_status_word   <= '0;
		end else begin
			toff_q             <= state_d == ST_TORQUE_OFF || state_d == ST_STOP_A; // [R1] [R8]
			safe_brake_control <= state_d == ST_TORQUE_OFF || state_d == ST_STOP_A; // [R8]
			// Only channel 0 commands the ramp; the other channel only watches
			quick_stop_ramp    <= state_d == ST_ACTIVE && !ext && sel_ch[0] | force_b_q; // [R8] [R14]
			if (sel || state_d != ST_IDLE) begin
				speed_setpoint_limit_out <= '0;                          // [R11]
			end else begin
				speed_setpoint_limit_out <= '{limit_q, limit_q, limit_q};
			end
			integrated_status_word.torque_off <= state_d == ST_TORQUE_OFF || state_d == ST_STOP_A; // [R13]
			integrated_status_word.stop_act   <= state_d == ST_ACTIVE || state_d == ST_STOP_F; // [R13]
			integrated_status_word.fault <= state_d == ST_STOP_A && force_b_q | viol;
			integrated_status_word.ext   <= ext && state_d == ST_ACTIVE;
		end
	end
	assign safe_torque_off = toff_q;

	// Interrupts: a new event wins over a clear in the same cycle
	always_comb begin
		istat_d = istat_q & ~iclr;
		istat_d[IRQ_TOFF] = istat_d[IRQ_TOFF] | (state_d == ST_TORQUE_OFF && !toff_q);
		istat_d[IRQ_MON] = istat_d[IRQ_MON] | (in_stop && viol);
		istat_d[IRQ_SYS] = istat_d[IRQ_SYS] | sys_evt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			istat_q <= '0;
			irq     <= 1'b0;
		end else begin
			istat_q <= istat_d;
			irq     <= |(istat_d & ien_q);
		end
	end

	// AXI4-Lite write path: address and data taken in either order
	assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
	assign iclr  = (wr_go && awaddr_q == ADDR_ICLR) ? wdata_q[IRQ_N-1:0] : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			awaddr_q      <= 8'h0;
			wdata_q       <= 32'h0;
			wstrb_q       <= 4'h0;
		end else begin
			s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_full_q && !s_axi_bvalid;
			s_axi_wready  <= s_axi_wvalid && !s_axi_wready && !w_full_q && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q <= ADDR_MSG && awaddr_q[1:0] == 2'h0 &&
					awaddr_q != ADDR_STATUS && awaddr_q != ADDR_ISTAT &&
					awaddr_q != ADDR_MSG) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q  <= CTRL_RST;
			mode_q  <= MODE_ACC_ENC;
			fcfg_q  <= 8'h0;
			delay_q <= DELAY_RST;
			thr_q   <= THR_RST;
			tol_q   <= TOL_RST;
			slope_q <= SLOPE_RST;
			limit_q <= LIMIT_RST;
			ien_q   <= '0;
		end else if (wr_go) begin
			unique case (awaddr_q)
				ADDR_CTRL:  ctrl_q  <= 3'(merge({29'h0, ctrl_q}, wdata_q, wstrb_q));
				ADDR_MODE:  mode_q  <= 2'(merge({30'h0, mode_q}, wdata_q, wstrb_q));
				ADDR_FCFG:  fcfg_q  <= 8'(merge({24'h0, fcfg_q}, wdata_q, wstrb_q));
				ADDR_DELAY: delay_q <= merge(delay_q, wdata_q, wstrb_q);
				ADDR_THR:   thr_q   <= 16'(merge({16'h0, thr_q}, wdata_q, wstrb_q));
				ADDR_TOL:   tol_q   <= 16'(merge({16'h0, tol_q}, wdata_q, wstrb_q));
				ADDR_SLOPE: slope_q <= 16'(merge({16'h0, slope_q}, wdata_q, wstrb_q));
				ADDR_LIMIT: limit_q <= 16'(merge({16'h0, limit_q}, wdata_q, wstrb_q));
				ADDR_IEN:   ien_q   <= IRQ_N'(merge({29'h0, ien_q}, wdata_q, wstrb_q));
				default: ;
			endcase
		end
	end

	// AXI4-Lite read path: one cycle to arready, data the cycle after
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				unique case (s_axi_araddr)
					ADDR_CTRL:   s_axi_rdata <= {29'h0, ctrl_q};
					ADDR_MODE:   s_axi_rdata <= {30'h0, mode_q};
					ADDR_FCFG:   s_axi_rdata <= {24'h0, fcfg_q};
					ADDR_DELAY:  s_axi_rdata <= delay_q;
					ADDR_THR:    s_axi_rdata <= {16'h0, thr_q};
					ADDR_TOL:    s_axi_rdata <= {16'h0, tol_q};
					ADDR_SLOPE:  s_axi_rdata <= {16'h0, slope_q};
					ADDR_LIMIT:  s_axi_rdata <= {16'h0, limit_q};
					ADDR_STATUS: s_axi_rdata <= integrated_status_word;     // [R13]
					ADDR_ISTAT:  s_axi_rdata <= {29'h0, istat_q};
					ADDR_ICLR:   s_axi_rdata <= 32'h0;
					ADDR_IEN:    s_axi_rdata <= {29'h0, ien_q};
					ADDR_MSG:    s_axi_rdata <= {16'h0, msg_q};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_toff_on_done: assert property ((state_q == ST_ACTIVE && done && !viol && !sys_evt
		&& !force_b_q) |=> toff_q && state_q == ST_TORQUE_OFF) else $error("no torque-off on done"); // [R1]
	a_timer_holds: assert property ((state_q == ST_ACTIVE && !sel) |=> state_q != ST_IDLE)
		else $error("stop aborted by deselect"); // [R2]
	a_toff_release: assert property ((state_q == ST_TORQUE_OFF && !sel && !sys_evt) |=>
		!toff_q && state_q == ST_IDLE) else $error("torque-off not released"); // [R2]
	a_acc_trip: assert property ((state_q == ST_ACTIVE && use_acc && viol && !sys_evt) |=>
		state_q == ST_STOP_A && toff_q) else $error("acceleration trip missed"); // [R3] [R5]
	a_ramp_trip: assert property ((state_q == ST_ACTIVE && use_ramp && viol && !sys_evt) |=>
		state_q == ST_STOP_A) else $error("brake ramp trip missed"); // [R4]
	a_speed_only: assert property ((state_q == ST_ACTIVE && !enc && mode_q == MODE_RAMP_NOENC
		&& !ext && spd[0] >= thr_q && spd[1] >= thr_q && !viol && !sys_evt) |=>
		state_q == ST_ACTIVE) else $error("timer acted in speed-only mode"); // [R6]
	a_ext_noramp: assert property ((ext && ctrl_q[CTRL_EN]) |=> !quick_stop_ramp || force_b_q)
		else $error("ramp in external stop"); // [R8]
	a_ext_nomon: assert property (ext |-> !viol) else $error("monitor active in external stop"); // [R9]
	a_ext_timer: assert property ((state_q == ST_ACTIVE && ext && timer_q[0] > 32'h1 &&
		timer_q[1] > 32'h1 && !sys_evt) |=> state_q == ST_ACTIVE) else $error("early torque-off"); // [R10]
	a_lim_zero: assert property (sel |=> speed_setpoint_limit_out == '0)
		else $error("setpoint limit not zero"); // [R11]
	a_sys_seq: assert property ((sys_evt && state_q == ST_IDLE) |=> state_q == ST_STOP_F
		##1 state_q == ST_ACTIVE && msg_q == MSG_SYS_ERR) else $error("stop F sequence wrong"); // [R12]
	a_status_bits: assert property ((state_q == ST_ACTIVE) |=> integrated_status_word.stop_act
		|| $past(state_d) != ST_ACTIVE) else $error("stop status missing"); // [R13]

	c_normal: cover property (state_q == ST_ACTIVE ##[1:20] state_q == ST_TORQUE_OFF);
	c_pulse: cover property (state_q == ST_TORQUE_OFF && !sel ##1 state_q == ST_IDLE);
	c_sys: cover property (state_q == ST_STOP_F ##[1:50] state_q == ST_STOP_A);
endmodule

`default_nettype wire

/* rtl/ssos_pkg.sv */
// Constants and types for the safe stop one sequencer.
// Assumes a single 20 MHz clock and an AXI4-Lite register port.
package ssos_pkg;
	localparam int          SPD_W         = 16;
	localparam int          ADDR_W        = 8;
	// Register byte offsets
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_MODE     = 8'h04;
	localparam logic [7:0]  ADDR_FCFG     = 8'h08;
	localparam logic [7:0]  ADDR_DELAY    = 8'h0c;
	localparam logic [7:0]  ADDR_THR      = 8'h10;
	localparam logic [7:0]  ADDR_TOL      = 8'h14;
	localparam logic [7:0]  ADDR_SLOPE    = 8'h18;
	localparam logic [7:0]  ADDR_LIMIT    = 8'h1c;
	localparam logic [7:0]  ADDR_STATUS   = 8'h20;
	localparam logic [7:0]  ADDR_ISTAT    = 8'h24;
	localparam logic [7:0]  ADDR_ICLR     = 8'h28;
	localparam logic [7:0]  ADDR_IEN      = 8'h2c;
	localparam logic [7:0]  ADDR_MSG      = 8'h30;
	// Field positions
	localparam int          CTRL_EN       = 0;
	localparam int          CTRL_ENC      = 1;
	localparam int          CTRL_SEL      = 2;
	localparam int          FCFG_EXT      = 3;
	localparam int          IRQ_TOFF      = 0;
	localparam int          IRQ_MON       = 1;
	localparam int          IRQ_SYS       = 2;
	localparam int          IRQ_N         = 3;
	// Monitoring-mode codes
	localparam logic [1:0]  MODE_ACC_ENC    = 2'h0;
	localparam logic [1:0]  MODE_RAMP_NOENC = 2'h1;
	localparam logic [1:0]  MODE_RAMP_ENC   = 2'h2;
	localparam logic [1:0]  MODE_ACC_NOENC  = 2'h3;
	// Reset values
	localparam logic [2:0]  CTRL_RST      = 3'h1;
	localparam logic [31:0] DELAY_RST     = 32'h0000_4e20;
	localparam logic [15:0] THR_RST       = 16'h0010;
	localparam logic [15:0] TOL_RST       = 16'h0020;
	localparam logic [15:0] SLOPE_RST     = 16'h0001;
	localparam logic [15:0] LIMIT_RST     = 16'hffff;
	localparam logic [15:0] MSG_SYS_ERR   = 16'h1711;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE       = 3'b000,
		ST_ACTIVE     = 3'b001,
		ST_TORQUE_OFF = 3'b010,
		ST_STOP_F     = 3'b011,
		ST_STOP_A     = 3'b100
	} ssos_state_t;

	typedef struct packed {
		logic [SPD_W-1:0] e2;
		logic [SPD_W-1:0] e1;
		logic [SPD_W-1:0] e0;
	} ssos_spd_lim_t;

	typedef struct packed {
		logic [27:0] rsvd;
		logic        ext;
		logic        fault;
		logic        stop_act;
		logic        torque_off;
	} ssos_status_t;
endpackage

/* sim/ssos_ctrl_model.sv */
// Higher-level controller model: safety selections and a motor that slows.
// Assumes one clock shared with the sequencer; the bench gives the commands.
`timescale 1ns/100ps
`default_nettype none
module ssos_ctrl_model (
	// Clock
	input  wire logic        aclk,
	// Bench commands
	input  wire logic        sel_req,
	input  wire logic        err_req,
	input  wire logic        ext_brake,
	input  wire logic        spd_load,
	input  wire logic [15:0] spd_init,
	input  wire logic [15:0] spd_dec,
	// Sequencer side
	input  wire logic        quick_stop_ramp,
	output logic [1:0]       select_pin,
	output logic             sys_error_pin,
	output logic [15:0]      speed_ch0,
	output logic [15:0]      speed_ch1
);
	logic [15:0] spd_q;
	logic        brk;
	// Both channels see one selection and one speed
	assign select_pin    = {sel_req, sel_req};
	assign sys_error_pin = err_req;
	assign speed_ch0     = spd_q;
	assign speed_ch1     = spd_q;
	// In external stop this side has to brake the motor itself
	assign brk           = quick_stop_ramp || ext_brake;
	always_ff @(posedge aclk) begin
		if (spd_load) begin
			spd_q <= spd_init;
		end else if (brk && spd_q > spd_dec) begin
			spd_q <= spd_q - spd_dec;
		end else if (brk) begin
			spd_q <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the safe stop one sequencer.
// Assumes the controller model drives selections and speed.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import ssos_pkg::*;
	// Short delay keeps runs brief; in use it must cover ramp and brake times
	localparam int DLY = 40;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  aw_a = 8'h00, ar_a = 8'h00;
	logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
	logic [31:0] w_d = 32'h0;
	logic [3:0]  w_s = 4'h0;
	logic        sel = 1'b0, err = 1'b0, extb = 1'b0, ld = 1'b0;
	logic [15:0] s_init = 16'h0, s_dec = 16'h0;
	logic        aw_r, w_r, b_v, ar_r, r_v, err_p, toff, brk_o, qsr, irq;
	logic [1:0]  b_rs, r_rs, sel_p;
	logic [31:0] r_d;
	logic [15:0] sp0, sp1;
	ssos_spd_lim_t lim_o;
	ssos_status_t  stw;
	logic [4:0]  obs;
	int          fails = 0;
	int          n_compared = 0;
	assign obs = {stw.ext, irq, qsr, brk_o, toff};
	always #25 aclk = ~aclk;
	ssos_top dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
		.s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
		.s_axi_bresp(b_rs), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
		.s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
		.s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
		.select_pin(sel_p), .sys_error_pin(err_p), .speed_ch0(sp0), .speed_ch1(sp1),
		.safe_torque_off(toff), .safe_brake_control(brk_o), .quick_stop_ramp(qsr),
		.speed_setpoint_limit_out(lim_o), .integrated_status_word(stw), .irq(irq)
	);
	ssos_ctrl_model ctrl (
		.aclk(aclk), .sel_req(sel), .err_req(err), .ext_brake(extb), .spd_load(ld),
		.spd_init(s_init), .spd_dec(s_dec), .quick_stop_ramp(qsr),
		.select_pin(sel_p), .sys_error_pin(err_p), .speed_ch0(sp0), .speed_ch1(sp1)
	);
	task automatic end_sim();
		if (fails == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, n, lim);
			end_sim();
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		aw_a <= a;
		aw_v <= 1'b1;
		w_d <= d;
		w_s <= 4'hf;
		w_v <= 1'b1;
		b_r <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (aw_v && aw_r) aw_v <= 1'b0;
			if (w_v && w_r) w_v <= 1'b0;
			if (b_v) break;
		end
		b_r <= 1'b0;
		tmo(n, 200);
		chk({30'h0, b_rs}, {30'h0, er});
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m,
			input logic [1:0] er);
		int n;
		@(posedge aclk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (ar_v && ar_r) ar_v <= 1'b0;
			if (r_v) break;
		end
		r_r <= 1'b0;
		tmo(n, 200);
		chk(r_d & m, ed);
		chk({30'h0, r_rs}, {30'h0, er});
	endtask
	task automatic wb(input int b, input logic v, input int lim, output int n);
		for (n = 0; n < lim; n++) begin
			@(posedge aclk);
			if (obs[b] === v) break;
		end
		tmo(n, lim);
	endtask
	task automatic cfg(input logic [31:0] ct, md, fc, dl);
		axw(ADDR_CTRL, ct, RESP_OKAY);
		axw(ADDR_MODE, md, RESP_OKAY);
		axw(ADDR_FCFG, fc, RESP_OKAY);
		axw(ADDR_DELAY, dl, RESP_OKAY);
	endtask
	task automatic spd(input logic [15:0] i, input logic [15:0] d);
		@(posedge aclk);
		s_init <= i;
		s_dec <= d;
		ld <= 1'b1;
		@(posedge aclk);
		ld <= 1'b0;
	endtask
	task automatic t_regs();
		axr(ADDR_CTRL, 32'h1, 32'hffff_ffff, RESP_OKAY);
		axr(ADDR_DELAY, 32'h4e20, 32'hffff_ffff, RESP_OKAY);
		axr(ADDR_THR, 32'h10, 32'hffff_ffff, RESP_OKAY);
		axr(ADDR_FCFG, 32'h0, 32'hffff_ffff, RESP_OKAY);
		axr(ADDR_STATUS, 32'h0, 32'hffff_ffff, RESP_OKAY);
		axr(8'h40, 32'h0, 32'hffff_ffff, RESP_SLVERR);
		axw(ADDR_STATUS, 32'h3, RESP_SLVERR);
		chk({16'h0, lim_o.e0}, 32'hffff);
	endtask
	task automatic t_timer(input logic [1:0] md, input logic [31:0] ct, input logic early);
		int n;
		cfg(ct, {30'h0, md}, 32'h0, DLY);
		spd(16'h0400, 16'h0001);
		sel <= 1'b1;
		wb(2, 1'b1, 10, n);
		chk({31'h0, |lim_o}, 32'h0);
		chk({28'h0, stw[3:0]}, 32'h2);
		if (early) sel <= 1'b0;
		wb(0, 1'b1, DLY + 20, n);
		chk(32'(n >= DLY - 2 && n <= DLY + 3), 32'h1);
		chk({30'h0, brk_o, qsr}, 32'h2);
		if (!early) begin
			repeat (5) @(posedge aclk);
			chk({28'h0, stw[3:0]}, 32'h1);
			sel <= 1'b0;
			wb(0, 1'b0, 10, n);
			axr(ADDR_ISTAT, 32'h1, 32'h1, RESP_OKAY);
			axw(ADDR_ICLR, 32'h1, RESP_OKAY);
		end else begin
			@(posedge aclk);
			chk({31'h0, toff}, 32'h0);
		end
		repeat (2) @(posedge aclk);
		chk({28'h0, stw[3:0]}, 32'h0);
	endtask
	task automatic t_speed(input logic [1:0] md, input logic [31:0] ct);
		int n;
		cfg(ct, {30'h0, md}, 32'h0, 32'd1000);
		spd(16'h0040, 16'h0002);
		sel <= 1'b1;
		wb(0, 1'b1, 80, n);
		chk(32'(n > 20), 32'h1);
		chk({31'h0, stw.fault}, 32'h0);
		sel <= 1'b0;
		wb(0, 1'b0, 10, n);
	endtask
	task automatic t_viol();
		int n;
		cfg(32'h3, {30'h0, MODE_ACC_ENC}, 32'h0, 32'd1000);
		spd(16'h0100, 16'h0001);
		sel <= 1'b1;
		wb(2, 1'b1, 10, n);
		spd(16'h0200, 16'h0001);
		wb(0, 1'b1, 10, n);
		chk({29'h0, stw[2:0]}, 32'h5);
		axr(ADDR_ISTAT, 32'h2, 32'h2, RESP_OKAY);
		sel <= 1'b0;
		axw(ADDR_CTRL, 32'h0, RESP_OKAY);
		wb(0, 1'b0, 10, n);
		axw(ADDR_ICLR, 32'h7, RESP_OKAY);
	endtask
	task automatic t_ext();
		int n;
		cfg(32'h0, {30'h0, MODE_RAMP_NOENC}, 32'h8, DLY);
		sel <= 1'b1;
		repeat (6) @(posedge aclk);
		chk({28'h0, stw[3:0]}, 32'h0);
		sel <= 1'b0;
		cfg(32'h1, {30'h0, MODE_RAMP_NOENC}, 32'h8, DLY);
		spd(16'h0100, 16'h0010);
		extb <= 1'b1;
		sel <= 1'b1;
		wb(4, 1'b1, 10, n);
		chk({30'h0, qsr, |lim_o}, 32'h0);
		sel <= 1'b0;
		wb(0, 1'b1, DLY + 20, n);
		chk(32'(n >= DLY - 6), 32'h1);
		chk({30'h0, brk_o, stw.fault}, 32'h2);
		@(posedge aclk);
		chk({31'h0, toff}, 32'h0);
		extb <= 1'b0;
		cfg(32'h1, 32'h0, 32'h0, DLY);
	endtask
	task automatic t_err();
		int n;
		axw(ADDR_IEN, 32'h7, RESP_OKAY);
		spd(16'h0400, 16'h0001);
		err <= 1'b1;
		repeat (2) @(posedge aclk);
		err <= 1'b0;
		wb(2, 1'b1, 10, n);
		wb(3, 1'b1, 10, n);
		axr(ADDR_MSG, 32'h1711, 32'hffff, RESP_OKAY);
		wb(0, 1'b1, DLY + 20, n);
		@(posedge aclk);
		chk({29'h0, stw[2:0]}, 32'h5);
		axw(ADDR_IEN, 32'h0, RESP_OKAY);
		wb(3, 1'b0, 5, n);
		axr(ADDR_ISTAT, 32'h4, 32'h4, RESP_OKAY);
		axw(ADDR_ICLR, 32'h7, RESP_OKAY);
		axr(ADDR_ISTAT, 32'h0, 32'h4, RESP_OKAY);
		repeat (5) @(posedge aclk);
		chk({31'h0, toff}, 32'h1);
		axw(ADDR_CTRL, 32'h0, RESP_OKAY);
		wb(0, 1'b0, 10, n);
	endtask
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		spd(16'h0000, 16'h0000);
		t_regs();
		t_timer(MODE_ACC_ENC, 32'h3, 1'b0);
		t_timer(MODE_ACC_NOENC, 32'h1, 1'b1);
		t_speed(MODE_RAMP_NOENC, 32'h1);
		t_speed(MODE_RAMP_ENC, 32'h3);
		t_viol();
		t_ext();
		t_err();
		end_sim();
	end
endmodule
`default_nettype wire
